// ===== irp_pkg.sv
// Package: register map, field layout, resets and timing for the ID/IO register bank
package irp_pkg;

  localparam logic [5:0] ADDR_CONV_WR = 6'h36;
  localparam logic [5:0] ADDR_CONV_SET = 6'h37;
  localparam logic [5:0] ADDR_CONV_CLR = 6'h38;
  localparam logic [5:0] ADDR_IO_WR = 6'h39;
  localparam logic [5:0] ADDR_IO_SET = 6'h3a;
  localparam logic [5:0] ADDR_IO_CLR = 6'h3b;

  // Conversion register field positions
  localparam int CONV_CODE_LSB = 0;
  localparam int CONV_DONE_BIT = 3;
  localparam int CONV_GO_BIT = 4;
  localparam int CONV_RSVD5_BIT = 5;
  localparam int CONV_IRQEN_BIT = 6;
  // Bits that software may write (code is read-only, done is hardware)
  localparam logic [7:0] CONV_WMASK = 8'h70;
  localparam logic [7:0] CONV_RESET = 8'h00;

  // IO and power register field positions
  localparam int IO_SWAP_BIT = 1;
  localparam int IO_SER_LVL_LSB = 2;
  localparam int IO_PU_PLUS_BIT = 4;
  localparam int IO_PU_MINUS_BIT = 5;
  localparam int IO_BUS_LVL_LSB = 6;
  localparam logic [7:0] IO_WMASK = 8'hfe;
  localparam logic [7:0] IO_RESET = 8'h04;

  localparam logic [2:0] CODE_ERROR = 3'h7;
  localparam logic [1:0] LVL_3V3 = 2'h0;

  // Conversion timing
  localparam int CLK_MHZ = 50;
  localparam int CONV_TIME_US = 282;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    IRP_ACC_WRITE = 2'b00,
    IRP_ACC_SET = 2'b01,
    IRP_ACC_CLEAR = 2'b10
  } irp_acc_type;

  // One register access from the link side
  typedef struct packed {
    logic wrStb;
    logic rdStb;
    logic [5:0] addr;
    logic [7:0] wdata;
  } irp_req_type;

  // Operating mode of the transceiver around the bank
  typedef struct packed {
    logic serialMode;
    logic audioMode;
    logic serialTransmitEnable;
  } irp_mode_type;

endpackage

// ===== irp_access_dec.sv
// Address decode of set/write/clear accesses for one register window
`timescale 1ns/10ps
`default_nettype none
module irp_access_dec #(
  parameter logic [5:0] BASE = 6'h00
) (
  input wire logic [5:0] addr,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic hit,
  output logic rdHit,
  output irp_pkg::irp_acc_type acc
);

  // Three consecutive addresses: base writes, +1 sets, +2 clears
  always_comb begin
    hit = 1'b0;
    rdHit = 1'b0;
    acc = irp_pkg::IRP_ACC_WRITE;
    if (addr == BASE) begin
      hit = wrStb;
      rdHit = rdStb;
    end else if (addr == 6'(BASE + 6'h01)) begin
      hit = wrStb;
      rdHit = rdStb;
      acc = irp_pkg::IRP_ACC_SET;
    end else if (addr == 6'(BASE + 6'h02)) begin
      hit = wrStb;
      rdHit = rdStb;
      acc = irp_pkg::IRP_ACC_CLEAR;
    end
  end

endmodule // irp_access_dec
`default_nettype wire

// ===== irp_id_converter.sv
// Timed ID-resistor conversion engine
`timescale 1ns/10ps
`default_nettype none
module irp_id_converter #(
  parameter int CYCLES = irp_pkg::CONV_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [2:0] measuredCode,
  output logic busy,
  output logic finish,
  output logic [2:0] code
);

  typedef enum logic [0:0] {
    IRP_IDLE = 1'b0,
    IRP_RUN = 1'b1
  } irp_cstate_type;

  irp_cstate_type state_r;
  logic [15:0] count_r;

  assign busy = (state_r == IRP_RUN);

  // Counts conversion time; code latched at the end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= IRP_IDLE;
      count_r <= 16'h0000;
      finish <= 1'b0;
      code <= 3'h0;
    end else begin
      finish <= 1'b0;
      unique case (state_r)
        IRP_IDLE: begin
          if (start) begin
            state_r <= IRP_RUN;
            count_r <= 16'(CYCLES - 1);
          end
        end
        IRP_RUN: begin
          if (count_r == 16'h0000) begin
            state_r <= IRP_IDLE;
            finish <= 1'b1;
            // Unused 110 reported as error
            code <= (measuredCode == 3'h6) ? irp_pkg::CODE_ERROR : measuredCode;
          end else begin
            count_r <= count_r - 16'h0001;
          end
        end
      endcase
    end
  end

endmodule // irp_id_converter
`default_nettype wire

// ===== irp_regs.sv
// ID-resistor conversion and IO/power control register bank
`timescale 1ns/10ps
`default_nettype none
module irp_regs (
  input wire logic clk,
  input wire logic arst_n,
  input wire irp_pkg::irp_req_type req,
  input wire irp_pkg::irp_mode_type mode,
  input wire logic carkitIrqEnable,
  input wire logic carkitStatusRead,
  input wire logic [2:0] measuredCode,
  output logic [7:0] rdata,
  output logic altInt,
  output logic [3:0] carkitView,
  output logic linePairSwap,
  output logic speakerSwap,
  output logic chargerPullupPlus,
  output logic chargerPullupMinus,
  output logic [1:0] regulatorLevel,
  output logic measureBusy
);

  logic [7:0] conv_r;
  logic [7:0] io_r;
  logic [2:0] code;
  logic convHit;
  logic convRd;
  logic ioHit;
  logic ioRd;
  logic busy;
  logic finish;
  logic goPulse;
  logic doneWasSet;
  logic [1:0] activeLevel_r;
  logic txEnPrev_r;
  logic [7:0] convNxt;
  logic [7:0] ioNxt;
  irp_pkg::irp_acc_type convAcc;
  irp_pkg::irp_acc_type ioAcc;

  ////////////////////////////////////////////////////////////////////
  // Address decode

  irp_access_dec #(.BASE(irp_pkg::ADDR_CONV_WR)) u_conv_dec (
    .addr(req.addr),
    .wrStb(req.wrStb),
    .rdStb(req.rdStb),
    .hit(convHit),
    .rdHit(convRd),
    .acc(convAcc)
  );

  irp_access_dec #(.BASE(irp_pkg::ADDR_IO_WR)) u_io_dec (
    .addr(req.addr),
    .wrStb(req.wrStb),
    .rdStb(req.rdStb),
    .hit(ioHit),
    .rdHit(ioRd),
    .acc(ioAcc)
  );

  ////////////////////////////////////////////////////////////////////
  // Conversion engine

  irp_id_converter u_conv (
    .clk(clk),
    .arst_n(arst_n),
    .start(goPulse),
    .measuredCode(measuredCode),
    .busy(busy),
    .finish(finish),
    .code(code)
  );

  // Merge a write/set/clear into the writable bits
  function automatic logic [7:0] merge(input logic [7:0] cur, input logic [7:0] wd,
                                       input irp_pkg::irp_acc_type acc,
                                       input logic [7:0] mask);
    logic [7:0] res;
    res = cur;
    unique case (acc)
      irp_pkg::IRP_ACC_WRITE: res = (cur & ~mask) | (wd & mask);
      irp_pkg::IRP_ACC_SET: res = cur | (wd & mask);
      irp_pkg::IRP_ACC_CLEAR: res = cur & ~(wd & mask);
      default: res = cur;
    endcase
    return res;
  endfunction

  // Next conversion value; bit 7 and code bits never writable
  always_comb begin
    convNxt = conv_r;
    if (convHit) begin
      convNxt = merge(conv_r, req.wdata, convAcc, irp_pkg::CONV_WMASK);
    end
    // Bit 5 forced to zero whatever the link writes
    convNxt[irp_pkg::CONV_RSVD5_BIT] = 1'b0;
  end

  // New measurement when start goes from 0 to 1 while idle
  assign goPulse = convNxt[irp_pkg::CONV_GO_BIT] & ~conv_r[irp_pkg::CONV_GO_BIT] & ~busy;
  assign doneWasSet = conv_r[irp_pkg::CONV_DONE_BIT];

  // Conversion register update; completion beats read-clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_r <= irp_pkg::CONV_RESET;
    end else begin
      conv_r[7] <= 1'b0;
      conv_r[irp_pkg::CONV_RSVD5_BIT] <= 1'b0;
      conv_r[irp_pkg::CONV_IRQEN_BIT] <= convNxt[irp_pkg::CONV_IRQEN_BIT];
      conv_r[2:0] <= code;
      if (finish) begin
        conv_r[irp_pkg::CONV_GO_BIT] <= 1'b0;
        conv_r[irp_pkg::CONV_DONE_BIT] <= 1'b1;
      end else begin
        conv_r[irp_pkg::CONV_GO_BIT] <= convNxt[irp_pkg::CONV_GO_BIT];
        if (convRd) begin
          conv_r[irp_pkg::CONV_DONE_BIT] <= 1'b0;
        end
      end
    end
  end

  // Interrupt on rising done with effective enable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      altInt <= 1'b0;
    end else begin
      altInt <= finish & ~doneWasSet
                & (conv_r[irp_pkg::CONV_IRQEN_BIT] | carkitIrqEnable);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // IO and power register

  always_comb begin
    ioNxt = io_r;
    if (ioHit) begin
      ioNxt = merge(io_r, req.wdata, ioAcc, irp_pkg::IO_WMASK);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_r <= irp_pkg::IO_RESET;
    end else begin
      io_r <= ioNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data; carkit view leaves done untouched

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
      carkitView <= 4'h0;
    end else begin
      // Carkit read shows done and code without clearing
      carkitView <= {conv_r[irp_pkg::CONV_DONE_BIT], conv_r[2:0]};
      if (convRd) begin
        rdata <= conv_r;
      end else if (ioRd) begin
        rdata <= io_r;
      end else if (req.rdStb) begin
        rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin and analog controls

  // Swap follows bit in USB and serial modes, never on speakers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      linePairSwap <= 1'b0;
      speakerSwap <= 1'b0;
    end else begin
      linePairSwap <= io_r[irp_pkg::IO_SWAP_BIT] & ~mode.audioMode;
      speakerSwap <= 1'b0;
    end
  end

  // Serial mode forces both pull-ups on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chargerPullupPlus <= 1'b0;
      chargerPullupMinus <= 1'b0;
    end else begin
      chargerPullupPlus <= io_r[irp_pkg::IO_PU_PLUS_BIT] | mode.serialMode;
      chargerPullupMinus <= io_r[irp_pkg::IO_PU_MINUS_BIT] | mode.serialMode;
    end
  end

  // Audio forces 3V3; serial level only latched when transmit enable rises; bus level otherwise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      activeLevel_r <= irp_pkg::LVL_3V3;
      txEnPrev_r <= 1'b0;
    end else begin
      txEnPrev_r <= mode.serialTransmitEnable;
      if (mode.audioMode) begin
        activeLevel_r <= irp_pkg::LVL_3V3;
      end else if (mode.serialMode) begin
        if (mode.serialTransmitEnable & ~txEnPrev_r) begin
          activeLevel_r <= io_r[irp_pkg::IO_SER_LVL_LSB +: 2];
        end
      end else begin
        activeLevel_r <= io_r[irp_pkg::IO_BUS_LVL_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regulatorLevel <= irp_pkg::LVL_3V3;
      measureBusy <= 1'b0;
    end else begin
      regulatorLevel <= activeLevel_r;
      measureBusy <= busy;
    end
  end

endmodule // irp_regs
`default_nettype wire

// ===== irp_regs_asserts.sv
// Port checker for the ID/IO register bank
`timescale 1ns/10ps
`default_nettype none
module irp_regs_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire irp_pkg::irp_req_type req,
  input wire irp_pkg::irp_mode_type mode,
  input wire logic carkitIrqEnable,
  input wire logic carkitStatusRead,
  input wire logic [2:0] measuredCode,
  input wire logic [7:0] rdata,
  input wire logic altInt,
  input wire logic [3:0] carkitView,
  input wire logic linePairSwap,
  input wire logic speakerSwap,
  input wire logic chargerPullupPlus,
  input wire logic chargerPullupMinus,
  input wire logic [1:0] regulatorLevel,
  input wire logic measureBusy
);
  int busyCnt;
  // Busy length, so a restart cannot stretch a conversion
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) busyCnt <= 0;
    else busyCnt <= measureBusy ? busyCnt + 1 : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_conv_length: assert property ($fell(measureBusy) |-> busyCnt >= irp_pkg::CONV_CYCLES - 1
    && busyCnt <= irp_pkg::CONV_CYCLES + 1) else $error("conversion length off");
  a_pullup_serial: assert property (mode.serialMode |=> chargerPullupPlus
    && chargerPullupMinus) else $error("pull-ups off in serial mode");
  a_audio_level: assert property (mode.audioMode ##1 mode.audioMode
    |=> regulatorLevel == irp_pkg::LVL_3V3) else $error("audio level not 3v3");
  a_audio_noswap: assert property (mode.audioMode |=> !linePairSwap)
    else $error("swap active in audio mode");
  a_speaker_fixed: assert property (!speakerSwap) else $error("speaker pins swapped");
  a_unmapped_read: assert property (req.rdStb && (req.addr < irp_pkg::ADDR_CONV_WR
    || req.addr > irp_pkg::ADDR_IO_CLR) |=> rdata == 8'h00) else $error("unmapped data");
  a_conv_reserved: assert property (req.rdStb && req.addr inside {[6'h36:6'h38]}
    |=> !rdata[7] && !rdata[5]) else $error("conversion reserved bit set");
  a_io_reserved: assert property (req.rdStb && req.addr inside {[6'h39:6'h3b]}
    |=> !rdata[0]) else $error("io reserved bit set");
  a_rdata_hold: assert property (!req.rdStb |=> $stable(rdata))
    else $error("read data moved");
  a_alt_pulse: assert property (altInt |=> !altInt) else $error("alt long");
  a_alt_done: assert property (altInt |-> ##[0:2] carkitView[3])
    else $error("alt without done");
  a_carkit_keep: assert property (carkitStatusRead && carkitView[3] && !$past(req.rdStb)
    |=> carkitView[3]) else $error("carkit read cleared done");
endmodule // irp_regs_asserts
bind irp_regs irp_regs_asserts chk (.clk, .arst_n, .req, .mode, .carkitIrqEnable,
  .carkitStatusRead, .measuredCode, .rdata, .altInt, .carkitView, .linePairSwap,
  .speakerSwap, .chargerPullupPlus, .chargerPullupMinus, .regulatorLevel, .measureBusy);
`default_nettype wire

// ===== irp_link_model.sv
// Link-side model issuing register accesses
`timescale 1ns/10ps
`default_nettype none
module irp_link_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output var irp_pkg::irp_req_type req
);
  // One access held over its taking edge, data caught next cycle
  task automatic access(input logic rd, input logic [5:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(negedge clk);
    req = '{wrStb: !rd, rdStb: rd, addr: a, wdata: d};
    @(posedge clk);
    @(negedge clk);
    req = '{wrStb: 1'b0, rdStb: 1'b0, addr: ~a, wdata: ~d}; // Idle bus shows junk
    q = rdata;
  endtask
  initial req = '0;
endmodule // irp_link_model
`default_nettype wire

// ===== irp_regs_tb.sv
// Self-checking bench for the ID/IO register bank
`timescale 1ns/10ps
`default_nettype none
module irp_regs_tb;
  typedef struct packed {
    logic [5:0] wa;
    logic [7:0] wd;
    logic [5:0] ra;
    logic [7:0] rd;
  } irp_row_type;
  logic clk = 0;
  logic arst_n = 0;
  irp_pkg::irp_req_type req;
  irp_pkg::irp_mode_type mode = '0;
  logic ckEn = 0;
  logic ckRd = 0;
  logic [2:0] code = 3'h0;
  logic [7:0] rdata;
  logic [7:0] q;
  logic altInt, swap, spk, puP, puM, busy;
  logic [3:0] view;
  logic [1:0] lvl;
  int badCount = 0;
  int compares = 0;
  int alts = 0;
  // Plain accesses; some conversion writes set bit 5, every conversion read expects it zero
  irp_row_type rows [10] = '{'{6'h36, 8'hc0, 6'h36, 8'h40}, '{6'h38, 8'h40, 6'h37, 8'h00},
    '{6'h37, 8'h60, 6'h38, 8'h40}, '{6'h38, 8'hff, 6'h36, 8'h00}, '{6'h39, 8'hff, 6'h39, 8'hfe},
    '{6'h3b, 8'h0c, 6'h3a, 8'hf2}, '{6'h3a, 8'h01, 6'h3b, 8'hf2}, '{6'h39, 8'h04, 6'h39, 8'h04},
    '{6'h3c, 8'hff, 6'h3c, 8'h00}, '{6'h35, 8'hff, 6'h39, 8'h04}};

  irp_link_model link (.clk(clk), .rdata(rdata), .req(req));
  irp_regs dut (.clk(clk), .arst_n(arst_n), .req(req), .mode(mode), .carkitIrqEnable(ckEn),
    .carkitStatusRead(ckRd), .measuredCode(code), .rdata(rdata), .altInt(altInt),
    .carkitView(view), .linePairSwap(swap), .speakerSwap(spk), .chargerPullupPlus(puP),
    .chargerPullupMinus(puM), .regulatorLevel(lvl), .measureBusy(busy));

  ////////////////////////////////////////////////////////////
  // Clock and interrupt pulse count
  always #10 clk = ~clk;
  always @(posedge clk) if (altInt === 1'b1) alts++;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    link.access(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    link.access(1'b1, a, 8'h00, q);
    check(q, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait, since a stuck converter must not hang the run
  task automatic waitDone();
    for (int i = 0; i < 15000 && busy !== 1'b0; i++) @(negedge clk);
    cyc(3);
  endtask
  task automatic finishTest();
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cyc(8);
    arst_n = 1;
    rd(6'h38, 8'h00);
    rd(6'h3a, 8'h04);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, rows[i].rd);
    end
    $display("end table");
    wr(6'h39, 8'hf2);
    cyc(3);
    check(8'({swap, puP, puM, lvl}), 8'h1f);
    mode.audioMode = 1;
    cyc(3);
    check(8'({swap, spk, lvl}), 8'h00);
    mode = '0;
    wr(6'h39, 8'h08);
    mode.serialMode = 1;
    cyc(2);
    mode.serialTransmitEnable = 1;
    cyc(3);
    check(8'({puP, puM, lvl}), 8'h0e);
    arst_n = 0;
    cyc(2);
    check(8'(lvl), 8'h00);
    mode = '0;
    arst_n = 1;
    rd(6'h39, 8'h04);
    $display("end pins");
    ckEn = 1;
    code = 3'h3;
    wr(6'h37, 8'h10);
    rd(6'h36, 8'h10);
    waitDone();
    ckRd = 1;
    cyc(1);
    ckRd = 0;
    check({view, alts[3:0]}, 8'hb1);
    rd(6'h36, 8'h0b);
    rd(6'h36, 8'h03);
    ckEn = 0;
    code = 3'h6;
    alts = 0;
    wr(6'h36, 8'h50);
    cyc(100);
    wr(6'h37, 8'h10);
    waitDone();
    check(8'(alts), 8'h01);
    rd(6'h37, 8'h4f);
    $display("end conversion");
    finishTest();
  end
  // Watchdog well past two conversions
  initial begin
    #2000000;
    badCount++;
    finishTest();
  end
endmodule // irp_regs_tb
`default_nettype wire
